// [core/rtcts_pkg.sv]
/*
   Shared constants and types for the real-time clock trim and status
   monitor: register offsets, field positions, reset values, trim code
   points and timing counts.
   Assumes a 40 MHz system clock and a 32.768 kHz crystal time base.
*/
package rtcts_pkg;

   // Register offsets on the register port
   localparam logic [3:0] ADDR_TRIM   = 4'h7;  // Trim register
   localparam logic [3:0] ADDR_CTRL1  = 4'he;  // Interrupt and alarm control
   localparam logic [3:0] ADDR_CTRL2  = 4'hf;  // Status and flag control

   // Field positions
   localparam int TRIM_PERIOD_BIT  = 7;        // trim_period_select
   localparam int CTRL2_THR_BIT    = 7;        // Supply threshold select
   localparam int CTRL2_LOW_BIT    = 6;        // low_supply_flag
   localparam int CTRL2_OSC_BIT    = 5;        // osc_running_flag
   localparam int CTRL2_PON_BIT    = 4;        // power_up_flag

   // Reset values
   localparam logic [7:0] TRIM_RST  = 8'h00;
   localparam logic [7:0] CTRL1_RST = 8'h00;
   localparam logic       PON_RST   = 1'b1;
   localparam logic       OSC_RST   = 1'b0;   // Indefinite; zero chosen

   // Interrupt pin modes in control register 1
   localparam logic [7:0] CTRL1_1HZ_MASK = 8'hcf; // Bits that must match
   localparam logic [7:0] CTRL1_1HZ_VAL  = 8'h03; // 1 Hz, 50 percent duty
   localparam logic [7:0] CTRL1_LOW_VAL  = 8'h01; // Pin fixed low
   localparam logic [7:0] CTRL1_CT_MASK  = 8'h07; // Periodic select field

   // Trim code points
   localparam logic [6:0] TRIM_NULL_A   = 7'h00;  // 0
   localparam logic [6:0] TRIM_NULL_B   = 7'h01;  // +1
   localparam logic [6:0] TRIM_NULL_C   = 7'h40;  // -64
   localparam logic [6:0] TRIM_NULL_D   = 7'h41;  // -63
   localparam logic [7:0] TRIM_GAIN_ORG = 8'h01;  // Zero point, gaining
   localparam logic [7:0] TRIM_LOSS_ORG = 8'h80;  // Zero point, losing
   localparam logic [15:0] TICKS_PER_STEP = 16'h0002; // Crystal ticks a step

   // Correction intervals in seconds
   localparam logic [5:0] INTERVAL_SHORT = 6'd20;
   localparam logic [5:0] INTERVAL_LONG  = 6'd60;

   // Timing
   localparam int OSC_HZ         = 32768;
   localparam int SAMPLE_TIME_US = 7800;
   localparam int SAMPLE_TICKS   =
      (SAMPLE_TIME_US * OSC_HZ + 999999) / 1000000;
   localparam int CLK_PERIOD_NS  = 25;
   localparam int HALT_TIME_NS   = 100000;
   localparam int HALT_CYCLES    =
      (HALT_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

   // Interrupt pin behaviour
   typedef enum logic [1:0] {
      INT_OFF = 2'b00,
      INT_LOW = 2'b01,
      INT_1HZ = 2'b10
   } rtcts_int_mode_e;

   // Configuration handed to the crystal domain
   typedef struct packed {
      logic       period_sel;      // trim_period_select
      logic [6:0] trim_value;      // trim_value_bit6 .. trim_value_bit0
      logic [7:0] ctrl1;           // Interrupt and alarm control
   } rtcts_cfg_s;

endpackage : rtcts_pkg

// [core/rtcts_top.sv]
/*
   Trim and status monitor of a real-time clock: register port, power-up,
   oscillator halt and low-supply flags, second timebase trimming and the
   1 Hz observation pulse.
   Assumes a host-side serial decoder on clk that issues one-cycle read
   and write strobes, a free-running crystal clock, and an asynchronous
   comparator output from the supply monitor.
*/
`timescale 1ns/1ps
`default_nettype none
module rtcts_top #(
   parameter int TICKS_PER_SEC = 32768     // Crystal ticks in one second
) (
   input  wire logic       clk,
   input  wire logic       sys_rst,
   input  wire logic       reg_wr_en,
   input  wire logic       reg_rd_en,
   input  wire logic [3:0] reg_addr,
   input  wire logic [7:0] reg_wdata,
   output logic      [7:0] reg_rdata,
   input  wire logic       osc_clk,
   input  wire logic       supply_low,
   output logic            supply_sample_en,
   output logic            supply_thr_sel,
   output logic            crystal_clock_output,
   output logic            intr_n
);

   // Host side registers
   logic [7:0]  trim_r;          // Trim register
   logic [7:0]  ctrl1_r;         // Interrupt and alarm control
   logic        pon_r;           // power_up_flag
   logic        xst_r;           // osc_running_flag
   logic        low_supply_flag_r;          // low_supply_flag
   logic        vdsl_r;          // Supply threshold select
   logic [7:0]  rdata_r;         // Read data
   logic        cfg_tgl_r;       // Toggles on each trim or control 1 write with power-up flag clear
   // Synchronisers into clk
   logic        low_m_r, low_s_r;
   logic        samp_m_r, samp_s_r;
   logic        alive_m_r, alive_s_r, alive_d_r;
   logic        alive_tgl_r;     // Crystal activity toggle for watchdog
   // Halt watchdog
   logic [11:0] halt_cnt_r;
   logic        osc_halt_r;
   // Decoded writes
   logic        wr_trim, wr_ctrl1, wr_ctrl2;

   assign wr_trim  = reg_wr_en && (reg_addr == rtcts_pkg::ADDR_TRIM);
   assign wr_ctrl1 = reg_wr_en && (reg_addr == rtcts_pkg::ADDR_CTRL1);
   assign wr_ctrl2 = reg_wr_en && (reg_addr == rtcts_pkg::ADDR_CTRL2);

   // Power-up flag: set by reset, host may only clear it
   always_ff @(posedge clk or posedge sys_rst) begin
      if (sys_rst) begin
         pon_r <= rtcts_pkg::PON_RST;
      end else if (wr_ctrl2 && !reg_wdata[rtcts_pkg::CTRL2_PON_BIT]) begin
         pon_r <= 1'b0;
      end
   end

   // Trim and control 1: cleared by reset, held while power-up flag set
   always_ff @(posedge clk or posedge sys_rst) begin
      if (sys_rst) begin
         trim_r  <= rtcts_pkg::TRIM_RST;
         ctrl1_r <= rtcts_pkg::CTRL1_RST;
      end else if (pon_r) begin
         trim_r  <= rtcts_pkg::TRIM_RST;
         ctrl1_r <= rtcts_pkg::CTRL1_RST;
      end else begin
         if (wr_trim) begin
            trim_r <= reg_wdata;
         end
         if (wr_ctrl1) begin
            ctrl1_r <= reg_wdata;
         end
      end
   end

   // Event toggle telling the crystal domain to take new settings
   always_ff @(posedge clk or posedge sys_rst) begin
      if (sys_rst) begin
         cfg_tgl_r <= 1'b0;
      end else if (!pon_r && (wr_trim || wr_ctrl1)) begin
         cfg_tgl_r <= ~cfg_tgl_r;
      end
   end

   // Threshold select, held at zero while power-up flag set
   always_ff @(posedge clk or posedge sys_rst) begin
      if (sys_rst) begin
         vdsl_r <= 1'b0;
      end else if (pon_r) begin
         vdsl_r <= 1'b0;
      end else if (wr_ctrl2) begin
         vdsl_r <= reg_wdata[rtcts_pkg::CTRL2_THR_BIT];
      end
   end

   // Synchronisers for pin and crystal domain signals
   always_ff @(posedge clk or posedge sys_rst) begin
      if (sys_rst) begin
         low_m_r   <= 1'b0;
         low_s_r   <= 1'b0;
         samp_m_r  <= 1'b0;
         samp_s_r  <= 1'b0;
         alive_m_r <= 1'b0;
         alive_s_r <= 1'b0;
         alive_d_r <= 1'b0;
      end else begin
         low_m_r   <= supply_low;
         low_s_r   <= low_m_r;
         samp_m_r  <= supply_sample_en;
         samp_s_r  <= samp_m_r;
         alive_m_r <= alive_tgl_r;
         alive_s_r <= alive_m_r;
         alive_d_r <= alive_s_r;
      end
   end

   // Low-supply flag: sampled in window, set beats host clear
   always_ff @(posedge clk or posedge sys_rst) begin
      if (sys_rst) begin
         low_supply_flag_r <= 1'b0;
      end else if (pon_r) begin
         low_supply_flag_r <= 1'b0;
      end else if (low_s_r && samp_s_r) begin
         low_supply_flag_r <= 1'b1;
      end else if (wr_ctrl2 && !reg_wdata[rtcts_pkg::CTRL2_LOW_BIT]) begin
         low_supply_flag_r <= 1'b0;
      end
   end

   // Watchdog on crystal activity; no edge for the halt time means halt
   always_ff @(posedge clk or posedge sys_rst) begin
      if (sys_rst) begin
         halt_cnt_r <= 12'h000;
         osc_halt_r <= 1'b0;
      end else if (alive_s_r != alive_d_r) begin
         halt_cnt_r <= 12'h000;
         osc_halt_r <= 1'b0;
      end else if (halt_cnt_r == 12'(rtcts_pkg::HALT_CYCLES - 1)) begin
         osc_halt_r <= 1'b1;
      end else begin
         halt_cnt_r <= halt_cnt_r + 12'h001;
      end
   end

   // Running flag: halt forces zero and wins over host writes
   always_ff @(posedge clk or posedge sys_rst) begin
      if (sys_rst) begin
         xst_r <= rtcts_pkg::OSC_RST;
      end else if (osc_halt_r) begin
         xst_r <= 1'b0;
      end else if (wr_ctrl2) begin
         xst_r <= reg_wdata[rtcts_pkg::CTRL2_OSC_BIT];
      end
   end

   // Registered read data; unmapped offsets read zero
   always_ff @(posedge clk or posedge sys_rst) begin
      if (sys_rst) begin
         rdata_r <= 8'h00;
      end else if (reg_rd_en) begin
         unique case (reg_addr)
            rtcts_pkg::ADDR_TRIM:  rdata_r <= trim_r;
            rtcts_pkg::ADDR_CTRL1: rdata_r <= ctrl1_r;
            rtcts_pkg::ADDR_CTRL2: rdata_r <= {vdsl_r, low_supply_flag_r, xst_r, pon_r,
                                               4'h0};
            default:               rdata_r <= 8'h00;
         endcase
      end
   end

   assign reg_rdata      = rdata_r;
   assign supply_thr_sel = vdsl_r;

   // ---- Crystal domain ----
   logic              orst_m_r, orst_r;   // Reset synchroniser
   logic              tgl_m_r, tgl_s_r, tgl_d_r;
   logic              low_supply_flag_m_r, low_supply_flag_s_r;
   rtcts_pkg::rtcts_cfg_s pend_r;         // Captured, not yet applied
   rtcts_pkg::rtcts_cfg_s act_r;          // Settings of current second
   logic [15:0]       tick_r;             // Tick within second
   logic [15:0]       len_r;              // Length of current second
   logic [5:0]        sec_r;              // Second within interval
   logic              intr_n_r;
   logic              samp_r;
   logic              sec_end, corr_sec, corr_next;
   logic [5:0]        last_sec, sec_next;
   rtcts_pkg::rtcts_int_mode_e mode;

   // Codes that leave the second alone
   function automatic logic trim_null(input logic [6:0] v);
      trim_null = (v == rtcts_pkg::TRIM_NULL_A) ||
                  (v == rtcts_pkg::TRIM_NULL_B) ||
                  (v == rtcts_pkg::TRIM_NULL_C) ||
                  (v == rtcts_pkg::TRIM_NULL_D);
   endfunction : trim_null

   // Length in ticks of a second with the given trim code
   function automatic logic [15:0] sec_len(input logic [6:0] v,
                                           input logic       corr);
      logic [15:0] base;
      logic [15:0] steps;
      base  = 16'(TICKS_PER_SEC);
      steps = 16'h0000;
      if (!corr || trim_null(v)) begin
         sec_len = base;
      end else if (!v[6]) begin
         // Fast count: lengthen the second
         steps   = 16'(8'({1'b0, v}) - rtcts_pkg::TRIM_GAIN_ORG);
         sec_len = base + 16'(steps * rtcts_pkg::TICKS_PER_STEP);
      end else begin
         // Slow count: shorten the second
         steps   = 16'(rtcts_pkg::TRIM_LOSS_ORG - 8'({1'b0, v}));
         sec_len = base - 16'(steps * rtcts_pkg::TICKS_PER_STEP);
      end
   endfunction : sec_len

   // Interrupt pin mode from control register 1
   always_comb begin
      if ((act_r.ctrl1 & rtcts_pkg::CTRL1_1HZ_MASK) ==
          rtcts_pkg::CTRL1_1HZ_VAL) begin
         mode = rtcts_pkg::INT_1HZ;
      end else if ((act_r.ctrl1 & rtcts_pkg::CTRL1_CT_MASK) ==
                   rtcts_pkg::CTRL1_LOW_VAL) begin
         mode = rtcts_pkg::INT_LOW;
      end else begin
         mode = rtcts_pkg::INT_OFF;
      end
   end

   assign last_sec  = pend_r.period_sel ? rtcts_pkg::INTERVAL_LONG - 6'd1 :
                      rtcts_pkg::INTERVAL_SHORT - 6'd1;
   assign sec_end   = (tick_r == len_r - 16'h0001);
   assign corr_sec  = (sec_r == (act_r.period_sel ?
                       rtcts_pkg::INTERVAL_LONG - 6'd1 :
                       rtcts_pkg::INTERVAL_SHORT - 6'd1));
   assign sec_next  = (sec_r >= last_sec) ? 6'd0 : sec_r + 6'd1;
   assign corr_next = (sec_next == last_sec);

   // Crystal domain reset: asserted at once, released on the crystal
   always_ff @(posedge osc_clk or posedge sys_rst) begin
      if (sys_rst) begin
         orst_m_r <= 1'b1;
         orst_r   <= 1'b1;
      end else begin
         orst_m_r <= 1'b0;
         orst_r   <= orst_m_r;
      end
   end

   // Crossings into the crystal domain and the activity toggle
   always_ff @(posedge osc_clk or posedge orst_r) begin
      if (orst_r) begin
         tgl_m_r     <= 1'b0;
         tgl_s_r     <= 1'b0;
         tgl_d_r     <= 1'b0;
         low_supply_flag_m_r    <= 1'b0;
         low_supply_flag_s_r    <= 1'b0;
         alive_tgl_r <= 1'b0;
      end else begin
         tgl_m_r     <= cfg_tgl_r;
         tgl_s_r     <= tgl_m_r;
         tgl_d_r     <= tgl_s_r;
         low_supply_flag_m_r    <= low_supply_flag_r;
         low_supply_flag_s_r    <= low_supply_flag_m_r;
         alive_tgl_r <= ~alive_tgl_r;
      end
   end

   // Capture settings once the toggle has crossed; registers are stable
   always_ff @(posedge osc_clk or posedge orst_r) begin
      if (orst_r) begin
         pend_r <= '0;
      end else if (tgl_s_r != tgl_d_r) begin
         pend_r <= '{period_sel: trim_r[rtcts_pkg::TRIM_PERIOD_BIT],
                     trim_value: trim_r[6:0], ctrl1: ctrl1_r};
      end
   end

   // Second and interval counters; settings apply at second boundary
   always_ff @(posedge osc_clk or posedge orst_r) begin
      if (orst_r) begin
         tick_r <= 16'h0000;
         len_r  <= 16'(TICKS_PER_SEC);
         sec_r  <= 6'd0;
         act_r  <= '0;
      end else if (sec_end) begin
         tick_r <= 16'h0000;
         sec_r  <= sec_next;
         act_r  <= pend_r;
         len_r  <= sec_len(pend_r.trim_value, corr_next);
      end else begin
         tick_r <= tick_r + 16'h0001;
      end
   end

   // Interrupt pin: low for first half of each (trimmed) second in 1 Hz mode, else fixed low or high
   always_ff @(posedge osc_clk or posedge orst_r) begin
      if (orst_r) begin
         intr_n_r <= 1'b1;
      end else begin
         unique case (mode)
            rtcts_pkg::INT_1HZ: intr_n_r <= !(tick_r < (len_r >> 1));
            rtcts_pkg::INT_LOW: intr_n_r <= 1'b0;
            rtcts_pkg::INT_OFF: intr_n_r <= 1'b1;
            default:            intr_n_r <= 1'b1;
         endcase
      end
   end

   // Supply sampling window at start of each second, off once flag set
   always_ff @(posedge osc_clk or posedge orst_r) begin
      if (orst_r) begin
         samp_r <= 1'b0;
      end else begin
         samp_r <= (tick_r < 16'(rtcts_pkg::SAMPLE_TICKS)) &&
                   !low_supply_flag_s_r;
      end
   end

   assign supply_sample_en     = samp_r;
   assign intr_n               = intr_n_r;
   assign crystal_clock_output = osc_clk;

   // ---- Checks, host clock ----
   chk_pon_holds_cfg: assert property (@(posedge clk) disable iff (sys_rst)
      pon_r |-> (trim_r == 8'h00 && ctrl1_r == 8'h00 && !low_supply_flag_r && !vdsl_r))
      else $error("settings not held at zero under power-up flag");
   chk_pon_no_rise: assert property (@(posedge clk) disable iff (sys_rst)
      !pon_r |=> !pon_r)
      else $error("power-up flag set again without reset");
   chk_halt_clears_osc: assert property (@(posedge clk) disable iff (sys_rst)
      osc_halt_r |=> !xst_r)
      else $error("running flag not cleared on halt");
   chk_osc_flag_sticky: assert property (@(posedge clk) disable iff (sys_rst)
      (!xst_r && !(wr_ctrl2 && reg_wdata[rtcts_pkg::CTRL2_OSC_BIT])) |=> !xst_r)
      else $error("running flag rose without host write");
   chk_low_flag_cause: assert property (@(posedge clk) disable iff (sys_rst)
      $rose(low_supply_flag_r) |-> $past(low_s_r && samp_s_r))
      else $error("low-supply flag set outside sample window");
   chk_low_flag_sticky: assert property (@(posedge clk) disable iff (sys_rst)
      (low_supply_flag_r && !(wr_ctrl2 && !reg_wdata[rtcts_pkg::CTRL2_LOW_BIT])) |=> low_supply_flag_r)
      else $error("low-supply flag cleared without host write");

   // ---- Checks, crystal clock ----
   chk_plain_second: assert property (@(posedge osc_clk) disable iff (orst_r)
      (sec_end && (!corr_sec || trim_null(act_r.trim_value))) |->
      len_r == 16'(TICKS_PER_SEC))
      else $error("uncorrected second has wrong length");
   chk_gain_second: assert property (@(posedge osc_clk) disable iff (orst_r)
      (sec_end && corr_sec && !act_r.trim_value[6] &&
       !trim_null(act_r.trim_value)) |->
      len_r == 16'(TICKS_PER_SEC) + 16'({act_r.trim_value, 1'b0}) - 16'h0002)
      else $error("gaining correction length wrong");
   chk_loss_second: assert property (@(posedge osc_clk) disable iff (orst_r)
      (sec_end && corr_sec && act_r.trim_value[6] &&
       !trim_null(act_r.trim_value)) |->
      len_r == 16'(TICKS_PER_SEC) - 16'h0100 + 16'({act_r.trim_value, 1'b0}))
      else $error("losing correction length wrong");
   chk_pulse_low_start: assert property (@(posedge osc_clk) disable iff (orst_r)
      (tick_r == 16'h0000 && mode == rtcts_pkg::INT_1HZ) |=> ##[0:1] !intr_n_r)
      else $error("1 Hz pulse not low at second start");
   chk_sample_stop: assert property (@(posedge osc_clk) disable iff (orst_r)
      low_supply_flag_s_r |=> !samp_r)
      else $error("supply sampled after low-supply flag set");

   cov_gain_second: cover property (@(posedge osc_clk) disable iff (orst_r)
      sec_end && corr_sec && len_r > 16'(TICKS_PER_SEC));
   cov_loss_second: cover property (@(posedge osc_clk) disable iff (orst_r)
      sec_end && corr_sec && len_r < 16'(TICKS_PER_SEC));
   cov_osc_halt: cover property (@(posedge clk) disable iff (sys_rst)
      $fell(xst_r) && osc_halt_r);
   cov_low_supply: cover property (@(posedge clk) disable iff (sys_rst)
      $rose(low_supply_flag_r));

endmodule : rtcts_top
`default_nettype wire

// [verif/rtcts_host.sv]
/*
   Host model: issues register writes and reads as one-cycle strobes and
   encodes signed trim steps into the 7-bit code.
   Assumes the bench calls its tasks and that clk is the design's clock.
*/
`timescale 1ns/1ps
`default_nettype none
module rtcts_host (
   input  wire logic       clk,
   output logic            reg_wr_en,
   output logic            reg_rd_en,
   output logic      [3:0] reg_addr,
   output logic      [7:0] reg_wdata,
   input  wire logic [7:0] reg_rdata
);
   // Idle port from time zero
   initial begin
      reg_wr_en = 1'b0;
      reg_rd_en = 1'b0;
      reg_addr  = 4'h0;
      reg_wdata = 8'h00;
   end

   // One write strobe, raised and dropped on falling edges
   task automatic wr(input logic [3:0] a, input logic [7:0] d);
      @(negedge clk);
      reg_addr  = a;
      reg_wdata = d;
      reg_wr_en = 1'b1;
      @(negedge clk);
      reg_wr_en = 1'b0;
      reg_wdata = ~d;                      // Released data is not kept
   endtask : wr

   // One read strobe; data is registered one edge later
   task automatic rd(input logic [3:0] a, output logic [7:0] d);
      @(negedge clk);
      reg_addr  = a;
      reg_rd_en = 1'b1;
      @(negedge clk);
      reg_rd_en = 1'b0;
      @(negedge clk);
      d = reg_rdata;
   endtask : rd

   // Signed steps to trim code; out-of-span steps fall back to no trim
   function automatic logic [6:0] trim_code(input int steps);
      if (steps < -62 || steps > 63) return 7'h00;
      if (steps >= 0) return 7'(steps + 1);
      return 7'(128 + steps);
   endfunction : trim_code
endmodule : rtcts_host
`default_nettype wire

// [verif/rtcts_top_tb_top.sv]
/*
   Bench for the trim and status monitor: registers, trimmed 1 Hz pulse,
   low-supply and oscillator halt flags, second reset.
   Assumes the package and the host model are compiled first.
*/
`timescale 1ns/1ps
`default_nettype none
`define CHK(nm, ex, got) begin n_checks++; if ((got) !== (ex)) begin \
   miscompares++; $display("mismatch %s exp %0h got %0h", nm, ex, got); \
   end end
module rtcts_top_tb_top;
   localparam int TPS = 128;           // Shortened second in crystal ticks
   logic       clk;                    // System clock
   logic       sys_rst;                // Power-on reset
   logic       osc_clk;                // Crystal clock
   logic       osc_run;                // Crystal running
   logic       supply_low;             // Comparator output
   logic       reg_wr_en;              // Write strobe
   logic       reg_rd_en;              // Read strobe
   logic [3:0] reg_addr;               // Offset
   logic [7:0] reg_wdata;              // Write data
   logic [7:0] reg_rdata;              // Read data
   logic       sample_en;              // Supply sampling window
   logic       thr_sel;                // Threshold select
   logic       clk_out;                // Crystal clock output
   logic       intr_n;                 // Interrupt pin
   logic [7:0] rdat;                   // Last read value
   int         miscompares;            // Mismatch count
   int         n_checks;               // Comparison count

   // System clock, 25 ns
   initial begin
      clk = 1'b0;
      forever #12.5 clk = ~clk;
   end
   // Crystal clock, 64 ns, offset phase, can be halted
   initial begin
      osc_clk = 1'b0;
      #7;
      forever begin
         #32;
         if (osc_run) osc_clk = ~osc_clk;
      end
   end

   rtcts_top #(.TICKS_PER_SEC(TPS)) u_dut (
      .clk(clk), .sys_rst(sys_rst), .reg_wr_en(reg_wr_en),
      .reg_rd_en(reg_rd_en), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
      .reg_rdata(reg_rdata), .osc_clk(osc_clk), .supply_low(supply_low),
      .supply_sample_en(sample_en), .supply_thr_sel(thr_sel),
      .crystal_clock_output(clk_out), .intr_n(intr_n));
   rtcts_host u_host (
      .clk(clk), .reg_wr_en(reg_wr_en), .reg_rd_en(reg_rd_en),
      .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_rdata(reg_rdata));

   // Verdict and end of run
   task automatic end_of_test;
      if (miscompares == 0 && n_checks > 0) $display("Run complete: PASS");
      else $display("Run complete: FAIL");
      $finish;
   endtask : end_of_test

   // Read one register and compare
   task automatic rd_chk(input logic [3:0] a, input logic [7:0] e,
                         input string nm);
      u_host.rd(a, rdat);
      `CHK(nm, e, rdat)
   endtask : rd_chk

   // One 1 Hz period, fall to fall, in crystal ticks
   task automatic next_fall(output int len, output int lo);
      logic p;
      len = 0;
      lo  = 0;
      do begin
         p = intr_n;
         @(posedge osc_clk);
         #1;
         len++;
         if (intr_n === 1'b0) lo++;
      end while (!(p === 1'b1 && intr_n === 1'b0));
   endtask : next_fall

   // Program trim, skip to the boundary, then judge n seconds
   task automatic set_trim(input logic dev, input logic [6:0] code,
                           input int n, input int alt);
      int len;
      int lo;
      int n_alt;
      int seen;
      realtime t0;
      u_host.wr(rtcts_pkg::ADDR_TRIM, {dev, code});
      rd_chk(rtcts_pkg::ADDR_TRIM, {dev, code}, "trim");
      n_alt = 0;
      seen  = TPS;
      next_fall(len, lo);
      next_fall(len, lo);
      for (int i = 0; i < n; i++) begin
         next_fall(len, lo);
         if (len != TPS) begin
            n_alt++;
            seen = len;
         end
         else `CHK("pulse low", TPS / 2, lo)
      end
      @(posedge clk_out);
      t0 = $realtime;
      @(posedge clk_out);
      `CHK("clock out", 64, int'($realtime - t0))
      `CHK("altered count", (alt == 0) ? 0 : 1, n_alt)
      `CHK("altered len", TPS + alt, seen)
   endtask : set_trim

   // Power-up values
   task automatic t_reset_state;
      rd_chk(rtcts_pkg::ADDR_TRIM, 8'h00, "trim rst");
      rd_chk(rtcts_pkg::ADDR_CTRL1, 8'h00, "ctrl1 rst");
      rd_chk(rtcts_pkg::ADDR_CTRL2, 8'h10, "ctrl2 rst");
      rd_chk(4'h3, 8'h00, "unmapped");
   endtask : t_reset_state

   // Settings held while the power-up flag is set
   task automatic t_pon_hold;
      u_host.wr(rtcts_pkg::ADDR_TRIM, 8'h09);
      u_host.wr(rtcts_pkg::ADDR_CTRL1, rtcts_pkg::CTRL1_1HZ_VAL);
      u_host.wr(rtcts_pkg::ADDR_CTRL2, 8'h90);
      rd_chk(rtcts_pkg::ADDR_TRIM, 8'h00, "trim held");
      rd_chk(rtcts_pkg::ADDR_CTRL1, 8'h00, "ctrl1 held");
      rd_chk(rtcts_pkg::ADDR_CTRL2, 8'h10, "pon kept");
      repeat (8) @(posedge osc_clk);
      `CHK("intr idle", 1'b1, intr_n)
   endtask : t_pon_hold

   // Flag write rules
   task automatic t_flags;
      u_host.wr(rtcts_pkg::ADDR_CTRL2, 8'he0);
      rd_chk(rtcts_pkg::ADDR_CTRL2, 8'h20, "pon clr");
      u_host.wr(rtcts_pkg::ADDR_CTRL2, 8'he0);
      rd_chk(rtcts_pkg::ADDR_CTRL2, 8'ha0, "flags wr");
      `CHK("thr sel", 1'b1, thr_sel)
      u_host.wr(rtcts_pkg::ADDR_CTRL2, 8'h20);
      rd_chk(rtcts_pkg::ADDR_CTRL2, 8'h20, "normal");
   endtask : t_flags

   // Trimmed 1 Hz pulse for gain, loss, long interval and null codes
   task automatic t_trim;
      u_host.wr(rtcts_pkg::ADDR_CTRL1, rtcts_pkg::CTRL1_1HZ_VAL | 8'h30);
      repeat (4) @(posedge osc_clk);       // Let the setting cross first
      set_trim(1'b0, u_host.trim_code(8), 20, 16);
      set_trim(1'b0, u_host.trim_code(-62), 20, -124);
      set_trim(1'b1, u_host.trim_code(8), 60, 16);
      set_trim(1'b0, rtcts_pkg::TRIM_NULL_A, 20, 0);
      set_trim(1'b0, rtcts_pkg::TRIM_NULL_B, 20, 0);
      set_trim(1'b0, rtcts_pkg::TRIM_NULL_C, 20, 0);
      set_trim(1'b0, rtcts_pkg::TRIM_NULL_D, 20, 0);
      u_host.wr(rtcts_pkg::ADDR_CTRL1, rtcts_pkg::CTRL1_LOW_VAL);
      repeat (2 * TPS + 8) @(posedge osc_clk);
      #1;
      `CHK("intr fixed low", 1'b0, intr_n)
   endtask : t_trim

   // Low supply sets the flag and stops sampling
   task automatic t_low;
      int k;
      k = 0;
      while (sample_en !== 1'b1 && k < 4 * TPS) begin
         @(posedge osc_clk);
         #1;
         k++;
      end
      `CHK("sample on", 1'b1, sample_en)
      @(negedge clk);
      supply_low = 1'b1;
      repeat (8) @(posedge osc_clk);
      @(negedge clk);
      supply_low = 1'b0;
      rd_chk(rtcts_pkg::ADDR_CTRL2, 8'h60, "low set");
      k = 0;
      repeat (2 * TPS) begin
         @(posedge osc_clk);
         #1;
         if (sample_en !== 1'b0) k++;
      end
      `CHK("sample off", 0, k)
      u_host.wr(rtcts_pkg::ADDR_CTRL2, 8'h20);
      rd_chk(rtcts_pkg::ADDR_CTRL2, 8'h20, "low clr");
   endtask : t_low

   // Oscillator halt clears the running flag until the host sets it
   task automatic t_halt;
      osc_run = 1'b0;
      repeat (4800) @(posedge clk);
      rd_chk(rtcts_pkg::ADDR_CTRL2, 8'h00, "halt");
      osc_run = 1'b1;
      repeat (400) @(posedge clk);
      rd_chk(rtcts_pkg::ADDR_CTRL2, 8'h00, "halt held");
      u_host.wr(rtcts_pkg::ADDR_CTRL2, 8'h20);
      rd_chk(rtcts_pkg::ADDR_CTRL2, 8'h20, "running");
   endtask : t_halt

   // Second power-on reset in mid-run
   task automatic t_rerst;
      @(negedge clk);
      sys_rst = 1'b1;
      repeat (6) @(negedge clk);
      sys_rst = 1'b0;
      t_reset_state;
   endtask : t_rerst

   // Main sequence; reset spans at least two crystal edges
   initial begin
      sys_rst     = 1'b1;
      supply_low  = 1'b0;
      osc_run     = 1'b1;
      miscompares = 0;
      n_checks    = 0;
      repeat (6) @(negedge clk);
      sys_rst = 1'b0;
      t_reset_state;
      t_pon_hold;
      t_flags;
      t_trim;
      t_low;
      t_halt;
      t_rerst;
      end_of_test;
   end

   // Watchdog past the expected run length
   initial begin
      #2500000;
      miscompares++;
      end_of_test;
   end
endmodule : rtcts_top_tb_top
`default_nettype wire
